// ---- design/vcsot_pkg.sv ----
// constants and register map of the capture sync and output timing block
package vcsot_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_SLICE = 8'h0f;
	localparam logic [7:0] IDX_SYNC = 8'h10;
	localparam logic [7:0] IDX_MODE = 8'h20;
	localparam logic [7:0] IDX_PERIOD = 8'h21;
	localparam logic [7:0] IDX_PHASE = 8'h22;
	localparam logic [7:0] IDX_HWIDTH = 8'h23;
	localparam logic [7:0] IDX_STATUS = 8'h24;
	// field positions
	localparam int SLICE_THR_LSB = 3;
	localparam int SLICE_SRC_BIT = 0;
	localparam int SYNC_LPOL_BIT = 6;
	localparam int SYNC_FPOL_BIT = 2;
	localparam int SYNC_FSRC_BIT = 0;
	localparam int MODE_DIG_BIT = 0;
	localparam int STAT_OVF_BIT = 16;
	localparam int STAT_SEEN_BIT = 17;
	// values after reset, and the smallest period accepted
	localparam logic [7:0] RST_SLICE = 8'h80;
	localparam logic [7:0] RST_SYNC = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_PERIOD = 8'h04;
	localparam logic [7:0] RST_PHASE = 8'h00;
	localparam logic [7:0] RST_HWIDTH = 8'h08;
	localparam logic [7:0] MIN_PERIOD = 8'h02;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// timing: a broad pulse longer than this is frame sync
	localparam int CLK_PERIOD_NS = 50;
	localparam int VSEP_NS = 10000;
	localparam int VSEP_CYCLES = (VSEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// pixel word layout in the buffer
	localparam int PIX_W = 25;
	localparam int PIX_HS_BIT = 24;
	localparam int FIFO_DEPTH = 8;
endpackage

// ---- design/vcsot_top.sv ----
// capture sync handling, pixel buffer and output timing
//
// Overview of operation
// RULE1 - polarity bit picks falling or rising edge
// RULE2 - leading edge locks sampling, trailing edge clamps
// RULE3 - line sync sets sampling reference and rate; code takes the rate from r_period
// RULE4 - slicer threshold from five configuration bits
// RULE5 - sliced sync output is non-inverted comparator
// RULE6 - sliced output selects comparator or delayed sync
// RULE7 - sliced output is raw composite, unprocessed
// RULE8 - line sync output rebuilt, aligned to clock
// RULE9 - line sync width programmable in analog only
// RULE10 - output clock from sampling clock, latches data
// RULE11 - phase change moves data, clock, sync together
// RULE12 - sample to output latency is fixed; code keeps it fixed only from an idle buffer with OUT_READY high
// RULE13 - one bit selects frame sync polarity
// RULE14 - frame sync separated or passed, unmodified
// RULE15 - shared 8-bit colour outputs, msb bit 7
// RULE16 - system wires luma green, chroma blue red
// RULE17 - digital path line sync follows transmitter timing
// RULE18 - sliced output source resets to comparator
`timescale 1ns/1ps
`default_nettype none

module vcsot_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic push;
	logic pop;

	// refuse depths that the pointer wrap cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end

	// honest full and empty from the fill count
	assign in_ready = cnt != (AW+1)'(DEPTH);
	assign out_valid = cnt != '0;
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage
	always_ff @(posedge clk) begin
		if (ce && push)
			mem[wp] <= in_data;
	end

	// pointers and count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else if (ce) begin
			if (push)
				wp <= wp + 1'b1;
			if (pop)
				rp <= rp + 1'b1;
			if (push && !pop)
				cnt <= cnt + 1'b1;
			else if (pop && !push)
				cnt <= cnt - 1'b1;
		end
	end
endmodule

module vcsot_top import vcsot_pkg::*; #(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic LINE_SYNC_IN,
	input wire logic FRAME_SYNC_IN,
	input wire logic GREEN_EMBEDDED_SYNC_IN,
	input wire logic [7:0] RED_VIDEO_IN,
	input wire logic [7:0] GREEN_VIDEO_IN,
	input wire logic [7:0] BLUE_VIDEO_IN,
	input wire logic DIG_VALID,
	input wire logic [7:0] DIG_RED,
	input wire logic [7:0] DIG_GREEN,
	input wire logic [7:0] DIG_BLUE,
	input wire logic DIG_LINE_SYNC,
	input wire logic DIG_FRAME_SYNC,
	input wire logic OUT_READY,
	output logic [7:0] RED_OUT,
	output logic [7:0] GREEN_OUT,
	output logic [7:0] BLUE_OUT,
	output logic PIXEL_OUT_CLOCK,
	output logic LINE_SYNC_OUT,
	output logic FRAME_SYNC_OUT,
	output logic SLICED_SYNC_OUT,
	output logic [4:0] SLICE_LEVEL,
	output logic CLAMP_PULSE,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP
);
	localparam logic [15:0] VSEP = 16'(VSEP_CYCLES);

	// refuse a buffer too shallow to hold a word in flight
	if (DEPTH < 2) begin : g_bad_depth
		$error("buffer depth too small");
	end

	logic [7:0] r_slice, r_sync, r_mode, r_period, r_phase, r_hwidth;
	logic [15:0] line_len, len_cnt;
	logic ovf, seen;
	logic [5:0] aw_idx;
	logic aw_got, w_got;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic hs_s1, hs_s2, hs_d, vs_s1, vs_s2, sg_s1, sg_s2, sg_d;
	logic lead, trail, line_pol, digital;
	logic running, tick, hs_act;
	logic [7:0] cnt, px_cnt;
	logic cap_valid;
	logic [PIX_W-1:0] cap_data;
	logic f_in_ready, f_out_valid, f_out_ready;
	logic [PIX_W-1:0] f_out;
	logic out_ph, pop;
	logic comp_act;
	logic [15:0] broad_cnt;
	logic frame_sep, frame_src;
	logic wr_do;

	assign line_pol = r_sync[SYNC_LPOL_BIT];
	assign digital = r_mode[MODE_DIG_BIT];

	// bus write: address and data taken in either order
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_idx <= '0;
			w_data <= '0;
			w_strb <= '0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else if (CLK_EN) begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_idx <= S_AXI_AWADDR[7:2];
				aw_got <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
				w_got <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_do) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	assign wr_do = aw_got && w_got && !S_AXI_BVALID;

	function automatic logic mapped(input logic [5:0] i);
		mapped = i == IDX_SLICE[5:0] || i == IDX_SYNC[5:0] ||
			i == IDX_MODE[5:0] || i == IDX_PERIOD[5:0] ||
			i == IDX_PHASE[5:0] || i == IDX_HWIDTH[5:0] ||
			i == IDX_STATUS[5:0];
	endfunction

	// configuration registers, byte lane 0
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			r_slice <= RST_SLICE; // RULE18
			r_sync <= RST_SYNC;
			r_mode <= RST_MODE;
			r_period <= RST_PERIOD;
			r_phase <= RST_PHASE;
			r_hwidth <= RST_HWIDTH;
		end else if (CLK_EN && wr_do && w_strb[0]) begin
			case (aw_idx)
				IDX_SLICE[5:0]: r_slice <= w_data[7:0]; // RULE4
				IDX_SYNC[5:0]: r_sync <= w_data[7:0];
				IDX_MODE[5:0]: r_mode <= w_data[7:0];
				IDX_PERIOD[5:0]: r_period <= (w_data[7:0] < MIN_PERIOD) ?
					MIN_PERIOD : w_data[7:0];
				IDX_PHASE[5:0]: r_phase <= w_data[7:0];
				IDX_HWIDTH[5:0]: r_hwidth <= w_data[7:0]; // RULE9
				default: ;
			endcase
		end
	end

	// bus read
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (CLK_EN) begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_word(S_AXI_ARADDR[7:2]);
				S_AXI_RRESP <= mapped(S_AXI_ARADDR[7:2]) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	function automatic logic [31:0] rd_word(input logic [5:0] i);
		rd_word = '0;
		case (i)
			IDX_SLICE[5:0]: rd_word[7:0] = r_slice;
			IDX_SYNC[5:0]: rd_word[7:0] = r_sync;
			IDX_MODE[5:0]: rd_word[7:0] = r_mode;
			IDX_PERIOD[5:0]: rd_word[7:0] = r_period;
			IDX_PHASE[5:0]: rd_word[7:0] = r_phase;
			IDX_HWIDTH[5:0]: rd_word[7:0] = r_hwidth;
			IDX_STATUS[5:0]: rd_word = {14'h0000, seen, ovf, line_len};
			default: rd_word = '0;
		endcase
	endfunction

	// pin synchronisers
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			{hs_s1, hs_s2, hs_d} <= 3'b000;
			{vs_s1, vs_s2} <= 2'b00;
			{sg_s1, sg_s2, sg_d} <= 3'b000;
		end else if (CLK_EN) begin
			hs_s1 <= LINE_SYNC_IN;
			hs_s2 <= hs_s1;
			hs_d <= hs_s2;
			vs_s1 <= FRAME_SYNC_IN;
			vs_s2 <= vs_s1;
			sg_s1 <= GREEN_EMBEDDED_SYNC_IN;
			sg_s2 <= sg_s1;
			sg_d <= sg_s2; // RULE5 RULE7
		end
	end

	// leading edge by polarity, trailing edge opposite
	assign lead = line_pol ? (hs_s2 && !hs_d) : (!hs_s2 && hs_d); // RULE1
	assign trail = line_pol ? (!hs_s2 && hs_d) : (hs_s2 && !hs_d); // RULE2

	// clamp timing from the trailing edge only
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N)
			CLAMP_PULSE <= 1'b0;
		else if (CLK_EN)
			CLAMP_PULSE <= trail && !digital; // RULE2
	end

	// line length measured between leading edges
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			len_cnt <= '0;
			line_len <= '0;
			seen <= 1'b0;
		end else if (CLK_EN) begin
			if (lead) begin
				line_len <= len_cnt; // RULE3
				len_cnt <= 16'h0001;
				seen <= 1'b1;
			end else if (len_cnt != 16'hffff) begin
				len_cnt <= len_cnt + 16'h0001;
			end
		end
	end

	// sampling ticks restart at every leading edge after the phase delay
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			running <= 1'b0;
			cnt <= '0;
		end else if (CLK_EN) begin
			if (lead) begin
				running <= 1'b1; // RULE2
				cnt <= r_phase; // RULE11
			end else if (running) begin
				cnt <= (cnt == 8'h00) ? r_period - 8'h01 : cnt - 8'h01; // RULE3
			end
		end
	end

	assign tick = running && !lead && cnt == 8'h00;

	// rebuilt line sync counted in sampling ticks
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			hs_act <= 1'b0;
			px_cnt <= '0;
		end else if (CLK_EN) begin
			if (lead) begin
				hs_act <= r_hwidth != 8'h00; // RULE8
				px_cnt <= '0;
			end else if (tick && hs_act) begin
				px_cnt <= px_cnt + 8'h01;
				if (px_cnt + 8'h01 >= r_hwidth)
					hs_act <= 1'b0; // RULE9
			end
		end
	end

	// capture stage: one word per tick or per digital pixel
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			cap_valid <= 1'b0;
			cap_data <= '0;
		end else if (CLK_EN) begin
			if (digital) begin
				cap_valid <= DIG_VALID;
				cap_data <= {DIG_LINE_SYNC, DIG_RED, DIG_GREEN, DIG_BLUE}; // RULE17
			end else begin
				cap_valid <= tick;
				cap_data <= {hs_act, RED_VIDEO_IN, GREEN_VIDEO_IN,
					BLUE_VIDEO_IN}; // RULE8
			end
		end
	end

	// sticky overflow when the buffer refuses a word; set wins over clear
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N)
			ovf <= 1'b0;
		else if (CLK_EN) begin
			if (cap_valid && !f_in_ready)
				ovf <= 1'b1;
			else if (wr_do && w_strb[2] && aw_idx == IDX_STATUS[5:0] &&
				w_data[STAT_OVF_BIT])
				ovf <= 1'b0;
		end
	end

	vcsot_fifo #(.WIDTH(PIX_W), .DEPTH(DEPTH)) u_fifo (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.ce(CLK_EN),
		.in_valid(cap_valid),
		.in_data(cap_data),
		.in_ready(f_in_ready),
		.out_valid(f_out_valid),
		.out_data(f_out),
		.out_ready(f_out_ready)
	);

	assign f_out_ready = !out_ph && OUT_READY; // RULE12
	assign pop = f_out_valid && f_out_ready;

	// output stage: data and sync change with clock low, clock rises next
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			out_ph <= 1'b0;
			PIXEL_OUT_CLOCK <= 1'b0;
			RED_OUT <= '0;
			GREEN_OUT <= '0;
			BLUE_OUT <= '0;
			LINE_SYNC_OUT <= 1'b0;
		end else if (CLK_EN) begin
			if (pop) begin
				out_ph <= 1'b1;
				PIXEL_OUT_CLOCK <= 1'b0; // RULE10
				RED_OUT <= f_out[23:16]; // RULE15
				GREEN_OUT <= f_out[15:8];
				BLUE_OUT <= f_out[7:0];
				LINE_SYNC_OUT <= f_out[PIX_HS_BIT]; // RULE11
			end else if (out_ph) begin
				out_ph <= 1'b0;
				PIXEL_OUT_CLOCK <= 1'b1; // RULE10
			end
		end
	end

	// slicer output and threshold
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			SLICED_SYNC_OUT <= 1'b0;
			SLICE_LEVEL <= RST_SLICE[7:3];
		end else if (CLK_EN) begin
			SLICE_LEVEL <= r_slice[7:SLICE_THR_LSB]; // RULE4
			SLICED_SYNC_OUT <= r_slice[SLICE_SRC_BIT] ? hs_d : sg_d; // RULE6
		end
	end

	assign comp_act = line_pol ? sg_s2 : !sg_s2;

	// frame sync separated from composite by broad pulse length
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			broad_cnt <= '0;
			frame_sep <= 1'b0;
		end else if (CLK_EN) begin
			if (!comp_act) begin
				broad_cnt <= '0;
				frame_sep <= 1'b0;
			end else begin
				if (broad_cnt != 16'hffff)
					broad_cnt <= broad_cnt + 16'h0001;
				if (broad_cnt >= VSEP)
					frame_sep <= 1'b1; // RULE14
			end
		end
	end

	always_comb begin
		frame_src = r_sync[SYNC_FSRC_BIT] ? vs_s2 : frame_sep;
		if (digital)
			frame_src = DIG_FRAME_SYNC;
	end

	// frame sync polarity select
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N)
			FRAME_SYNC_OUT <= 1'b0;
		else if (CLK_EN)
			FRAME_SYNC_OUT <= frame_src ^ r_sync[SYNC_FPOL_BIT]; // RULE13
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N || !CLK_EN);

	// helper: cycles since the last leading edge, first tick marker
	logic [8:0] since_lead;
	logic first_tick;
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			since_lead <= '0;
			first_tick <= 1'b0;
		end else if (CLK_EN) begin
			if (lead) begin
				since_lead <= '0;
				first_tick <= 1'b1;
			end else begin
				if (since_lead != 9'h1ff)
					since_lead <= since_lead + 9'h001;
				if (tick)
					first_tick <= 1'b0;
			end
		end
	end

	AST_LEAD_POL: assert property (lead |-> (hs_s2 == line_pol)) // RULE1
		else $error("leading edge in wrong sense");
	AST_TRAIL_CLAMP: assert property (trail && !digital // RULE2
		|=> CLAMP_PULSE ##1 !CLAMP_PULSE || trail)
		else $error("clamp not timed from trailing edge");
	AST_FIRST_TICK: assert property (tick && first_tick // RULE3
		|-> since_lead == {1'b0, r_phase})
		else $error("first sample not at phase delay");
	AST_SLICE_LVL: assert property (##1 SLICE_LEVEL == // RULE4
		$past(r_slice[7:3]))
		else $error("slicer threshold mismatch");
	AST_SLICED_SRC: assert property (!r_slice[SLICE_SRC_BIT] // RULE5
		|=> SLICED_SYNC_OUT == $past(sg_d))
		else $error("sliced output not raw comparator");
	AST_SLICED_HS: assert property (r_slice[SLICE_SRC_BIT] // RULE6
		|=> SLICED_SYNC_OUT == $past(hs_s2, 2))
		else $error("sliced output not delayed line sync");
	AST_ALIGN: assert property ($rose(PIXEL_OUT_CLOCK) |-> // RULE11
		$stable(LINE_SYNC_OUT) && $stable(RED_OUT))
		else $error("data moved at output clock edge");
	AST_DIG_HS: assert property (digital |=> // RULE17
		cap_data[PIX_HS_BIT] == $past(DIG_LINE_SYNC))
		else $error("digital line sync altered");
	// a word into an idle buffer pops next cycle, shows the one after
	AST_LATENCY: assert property (cap_valid && !f_out_valid // RULE12
		&& !out_ph ##1 OUT_READY |-> pop
		##1 RED_OUT == $past(cap_data[23:16], 2))
		else $error("latency not fixed");
	AST_PIXCLK: assert property (pop |=> !PIXEL_OUT_CLOCK // RULE10
		##1 PIXEL_OUT_CLOCK)
		else $error("output clock sequence wrong");
	AST_RGB: assert property (pop |=> // RULE15
		RED_OUT == $past(f_out[23:16]) && BLUE_OUT == $past(f_out[7:0]))
		else $error("colour word mismatch");
	AST_FRAME_POL: assert property (digital |=> FRAME_SYNC_OUT == // RULE13
		($past(DIG_FRAME_SYNC) ^ $past(r_sync[SYNC_FPOL_BIT])))
		else $error("frame sync polarity wrong");
	AST_RST_SRC: assert property (disable iff (1'b0) // RULE18
		!RESET_N |=> !r_slice[SLICE_SRC_BIT])
		else $error("slicer source not comparator after reset");

	COV_TICK: cover property (lead ##[1:20] tick);
	COV_POP: cover property (pop ##2 pop);
	COV_FULL: cover property (cap_valid && !f_in_ready);
	COV_FRAME: cover property ($rose(frame_sep));
endmodule

`default_nettype wire

// ---- bench/vcsot_sink.sv ----
// downstream model that takes pixel words on the output clock rise
`timescale 1ns/1ps
`default_nettype none
module vcsot_sink (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic pix_clk,
	input wire logic [24:0] word,
	output logic ready,
	output int got,
	output logic [24:0] last
);
	logic pix_q;
	// ready follows the stall request one cycle late, like a slow consumer
	always_ff @(posedge clk) begin
		pix_q <= pix_clk;
		ready <= rst_n && !stall;
		if (!rst_n) begin
			got <= 0;
			last <= '0;
		end else if (pix_clk && !pix_q) begin
			got <= got + 1;
			last <= word; // latch on rise, data settled a cycle earlier
		end
	end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// testbench for the capture sync and output timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import vcsot_pkg::*;
	logic clk, rst_n, line_in, frame_in, green_sync, dig_valid, dig_hs;
	logic stall, link_on, awv, wv, bready, arv, rready, out_rdy, hs_seen;
	logic [7:0] vid, dr, dg, db, awaddr, araddr, ro, go, bo;
	logic [31:0] wdata, rd_bus, q;
	logic awr, wrdy, bv, arr, rv, pclk, hs_out, fs_out, ss_out, clamp;
	logic [4:0] lvl;
	logic ce, dig_fs;
	logic [1:0] bresp, rresp;
	logic [24:0] last;
	int got, mismatches, samples_checked, n0, n, c, g0;
	logic [7:0] ridx [4] = '{IDX_SLICE, IDX_SYNC, IDX_PERIOD, IDX_HWIDTH};
	logic [7:0] rval [4] = '{RST_SLICE, RST_SYNC, RST_PERIOD, RST_HWIDTH};

	vcsot_top dut (.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(ce),
		.LINE_SYNC_IN(line_in), .FRAME_SYNC_IN(frame_in),
		.GREEN_EMBEDDED_SYNC_IN(green_sync), .RED_VIDEO_IN(vid),
		.GREEN_VIDEO_IN(~vid), .BLUE_VIDEO_IN(vid ^ 8'h0f),
		.DIG_VALID(dig_valid), .DIG_RED(dr), .DIG_GREEN(dg), .DIG_BLUE(db),
		.DIG_LINE_SYNC(dig_hs), .DIG_FRAME_SYNC(dig_fs), .OUT_READY(out_rdy),
		.RED_OUT(ro), .GREEN_OUT(go), .BLUE_OUT(bo), .PIXEL_OUT_CLOCK(pclk),
		.LINE_SYNC_OUT(hs_out), .FRAME_SYNC_OUT(fs_out),
		.SLICED_SYNC_OUT(ss_out), .SLICE_LEVEL(lvl), .CLAMP_PULSE(clamp),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awaddr),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
		.S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_ARADDR(araddr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
		.S_AXI_RDATA(rd_bus), .S_AXI_RRESP(rresp));

	vcsot_sink sink (.clk(clk), .rst_n(rst_n), .stall(stall),
		.pix_clk(pclk), .word({hs_out, ro, go, bo}), .ready(out_rdy),
		.got(got), .last(last));

	// core clock
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	// line sync as a 400 ns link clock, still outside frames
	initial begin
		forever begin
			repeat (4) @(posedge clk);
			if (link_on) line_in <= ~line_in;
		end
	end

	// remember any rebuilt line sync pulse
	always @(posedge clk) begin
		if (!rst_n) hs_seen <= 1'b0;
		else if (hs_out === 1'b1) hs_seen <= 1'b1;
	end

	task automatic chk(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one register access; byte address is four times the index
	task automatic acc(input logic wr, input logic [7:0] idx,
		input logic [31:0] d, input logic [1:0] er, output logic [31:0] r);
		@(posedge clk);
		if (wr) begin
			awaddr <= {idx[5:0], 2'b00};
			wdata <= d;
			awv <= 1;
			wv <= 1;
			bready <= 1;
		end else begin
			araddr <= {idx[5:0], 2'b00};
			arv <= 1;
			rready <= 1;
		end
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 0;
			if (wv && wrdy) wv <= 0;
			if (arv && arr) arv <= 0;
		end while (!(wr ? bv : rv));
		r = rd_bus;
		chk("bus response", wr ? bresp : rresp, er);
		bready <= 0;
		rready <= 0;
	endtask

	// move line sync, then count clamp pulses and cycles before sync out
	task automatic probe(input logic lv, output int hn, output int cn);
		line_in <= lv;
		hn = 0;
		cn = 0;
		repeat (30) begin
			@(posedge clk);
			if (clamp === 1'b1) cn++;
			if (hs_out !== 1'b1) hn++;
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// watchdog well beyond the expected thousand or so cycles
	initial begin
		#1000000;
		mismatches++;
		end_of_test;
	end

	initial begin
		{line_in, frame_in, green_sync, dig_valid, dig_hs, stall} = '0;
		{link_on, awv, wv, bready, arv, rready, rst_n, dig_fs} = '0;
		ce = 1;
		{vid, dr, dg, db, awaddr, araddr, wdata} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1;
		// register values after reset and an unmapped index
		foreach (ridx[i]) begin
			acc(0, ridx[i], 0, RESP_OKAY, q);
			chk("reset value", q, {24'h0, rval[i]});
		end
		chk("slice level", lvl, 32'h10);
		acc(0, 8'h30, 0, RESP_SLVERR, q);
		chk("unmapped read", q, 32'h0);
		$display("test registers done");
		// threshold and sliced output source
		acc(1, IDX_SLICE, 32'hf8, RESP_OKAY, q);
		repeat (5) @(posedge clk);
		chk("slice level", lvl, 32'h1f);
		chk("sliced out", ss_out, 32'h0);
		ce <= 0;
		green_sync <= 1;
		repeat (5) @(posedge clk);
		chk("sliced out frozen", ss_out, 32'h0);
		ce <= 1;
		repeat (5) @(posedge clk);
		chk("sliced out", ss_out, 32'h1);
		green_sync <= 0;
		acc(1, IDX_SLICE, 32'h81, RESP_OKAY, q);
		line_in <= 1;
		repeat (5) @(posedge clk);
		chk("sliced out", ss_out, 32'h1);
		line_in <= 0;
		repeat (5) @(posedge clk);
		chk("sliced out", ss_out, 32'h0);
		$display("test slicer done");
		// frame sync direct, inverted and separated
		frame_in <= 1;
		acc(1, IDX_SYNC, 32'h01, RESP_OKAY, q);
		repeat (5) @(posedge clk);
		chk("frame out", fs_out, 32'h1);
		acc(1, IDX_SYNC, 32'h05, RESP_OKAY, q);
		repeat (5) @(posedge clk);
		chk("frame out", fs_out, 32'h0);
		green_sync <= 1;
		acc(1, IDX_SYNC, 32'h00, RESP_OKAY, q);
		repeat (5) @(posedge clk);
		chk("frame out", fs_out, 32'h0);
		green_sync <= 0;
		repeat (150) @(posedge clk);
		chk("frame out", fs_out, 32'h0);
		repeat (60) @(posedge clk);
		chk("frame out", fs_out, 32'h1);
		green_sync <= 1;
		frame_in <= 0;
		repeat (5) @(posedge clk);
		chk("frame out", fs_out, 32'h0);
		$display("test frame sync done");
		// analog capture locked to a running line sync
		vid <= 8'h5a;
		link_on <= 1;
		repeat (120) @(posedge clk);
		acc(0, IDX_STATUS, 0, RESP_OKAY, q);
		chk("line period", q[15:0], 32'h8);
		chk("line seen", q[STAT_SEEN_BIT], 32'h1);
		chk("pixel word", last[23:0], 32'h5aa555);
		chk("sync out seen", hs_seen, 32'h1);
		link_on <= 0;
		$display("test analog stream done");
		// edge roles and phase shift
		@(posedge clk);
		line_in <= 1;
		repeat (60) @(posedge clk);
		probe(0, n0, c);
		chk("clamp on lead", c, 32'h0);
		probe(1, n, c);
		chk("clamp on trail", c, 32'h1);
		acc(1, IDX_PHASE, 32'h03, RESP_OKAY, q);
		repeat (40) @(posedge clk);
		probe(0, n, c);
		chk("sync out shift", n - n0, 32'h3);
		probe(1, n, c);
		acc(1, IDX_SYNC, 32'h40, RESP_OKAY, q);
		repeat (40) @(posedge clk);
		probe(0, n, c);
		chk("clamp on trail", c, 32'h1);
		$display("test edges done");
		// digital path into a stalled buffer, then drain
		acc(1, IDX_MODE, 32'h01, RESP_OKAY, q);
		acc(1, IDX_HWIDTH, 32'h01, RESP_OKAY, q);
		stall <= 1;
		repeat (60) @(posedge clk);
		g0 = got;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			dig_valid <= 1;
			dr <= i[7:0];
			dg <= 8'(i + 16);
			db <= 8'(i + 32);
			dig_hs <= i[0];
			@(posedge clk);
			dig_valid <= 0;
		end
		repeat (5) @(posedge clk);
		acc(0, IDX_STATUS, 0, RESP_OKAY, q);
		chk("overflow", q[STAT_OVF_BIT], 32'h1);
		stall <= 0;
		repeat (80) @(posedge clk);
		chk("words drained", got - g0, FIFO_DEPTH);
		chk("last word", last, 32'h1071727);
		dig_fs <= 1;
		repeat (3) @(posedge clk);
		chk("frame out", fs_out, 32'h1);
		dig_fs <= 0;
		acc(1, IDX_STATUS, 32'h10000, RESP_OKAY, q);
		acc(0, IDX_STATUS, 0, RESP_OKAY, q);
		chk("overflow clear", q[STAT_OVF_BIT], 32'h0);
		$display("test digital buffer done");
		end_of_test;
	end
endmodule
`default_nettype wire
